// [apc_capture.v]
// Address and request capture for the processor system bus, device side.
// Assumes all bus pins are asynchronous to clock; strobes are much slower than clock.
`default_nettype none
`include "apc_regs.vh"

module apc_capture (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Bus pins, active low
  input wire [`APC_ADDR_MSB:`APC_ADDR_LSB] address_lines_n,
  input wire [`APC_REQ_W-1:0] request_lines_n,
  input wire [1:0] address_parity_lines_n,
  input wire address_capture_strobe_zero_n,
  input wire address_capture_strobe_one_n,
  input wire address_valid_strobe_n,
  input wire address_wrap_mask_in_n,
  // Captured request towards decode and snoop
  output reg [`APC_ADDR_MSB:`APC_ADDR_LSB] req_address,
  output reg [`APC_REQ_W-1:0] req_type,
  output reg req_start,
  output reg req_parity_error,
  output reg wrap_mask_active
);

  // Synchronised data pins
  reg [`APC_ADDR_W-1:0] addr_meta;
  reg [`APC_ADDR_W-1:0] addr_sync;
  reg [`APC_REQ_W-1:0] req_meta;
  reg [`APC_REQ_W-1:0] req_sync;
  reg [1:0] par_meta;
  reg [1:0] par_sync;
  reg mask_meta;
  reg mask_sync;

  // Capture holding registers, true polarity
  // Reset to the idle bus, which reads as all zeros in true polarity
  reg [`APC_STB0_MSB:`APC_ADDR_LSB] low_half;
  reg [`APC_ADDR_MSB:`APC_STB1_LSB] high_half;
  reg [`APC_REQ_W-1:0] req_held;
  reg [1:0] par_held;
  reg [1:0] phase;
  reg [1:0] next_phase;

  wire stb0_fall;
  wire stb1_fall;
  wire valid_fall;

  // Strobes and valid are seen as falling edges two clocks after the pin
  // A strobe low for less than one clock may be missed; the link must stay slower
  apc_sync_edge u_stb0 (
    .clock(clock),
    .resetn(resetn),
    .async_in(address_capture_strobe_zero_n),
    .level(),
    .fall(stb0_fall)
  );

  apc_sync_edge u_stb1 (
    .clock(clock),
    .resetn(resetn),
    .async_in(address_capture_strobe_one_n),
    .level(),
    .fall(stb1_fall)
  );

  apc_sync_edge u_valid (
    .clock(clock),
    .resetn(resetn),
    .async_in(address_valid_strobe_n),
    .level(),
    .fall(valid_fall)
  );

  // Data pins pass two flops so they line up with the strobe edge detect
  // The word is coherent only because the driver holds it for clocks around each strobe
  always @(posedge clock) begin
    if (!resetn) begin
      addr_meta <= {`APC_ADDR_W{1'b1}};
      addr_sync <= {`APC_ADDR_W{1'b1}};
      req_meta <= {`APC_REQ_W{1'b1}};
      req_sync <= {`APC_REQ_W{1'b1}};
      par_meta <= 2'h3;
      par_sync <= 2'h3;
      mask_meta <= 1'b1;
      mask_sync <= 1'b1;
    end else begin
      addr_meta <= address_lines_n;
      addr_sync <= addr_meta;
      req_meta <= request_lines_n;
      req_sync <= req_meta;
      par_meta <= address_parity_lines_n;
      par_sync <= par_meta;
      mask_meta <= address_wrap_mask_in_n;
      mask_sync <= mask_meta;
    end
  end

  // Parity of the held address; odd count of low lines gives low-level parity
  wire [`APC_ADDR_W-1:0] held_addr = {high_half, low_half};
  wire addr_par_hi = ^held_addr[`APC_ADDR_W-1:21];
  wire addr_par_lo = ^{held_addr[20:0], req_held};
  // Upper field paired with parity line zero, lower field and request with line one
  wire par_bad = (addr_par_hi != par_held[0]) | (addr_par_lo != par_held[1]);

  // Wrap at 1 MB
  // Only the wrap bit is gated; every other bit passes untouched
  wire [`APC_ADDR_MSB:`APC_ADDR_LSB] masked_addr;
  genvar idx;
  generate
    for (idx = `APC_ADDR_LSB; idx <= `APC_ADDR_MSB; idx = idx + 1) begin : g_mask
      if (idx == `APC_WRAP_BIT) begin : g_wrap
        assign masked_addr[idx] = held_addr[idx-`APC_ADDR_LSB] & mask_sync;
      end else begin : g_pass
        assign masked_addr[idx] = held_addr[idx-`APC_ADDR_LSB];
      end
    end
  endgenerate

  // Request phases, binary coded
  // One request is followed at a time; overlapping requests are not queued
  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_LOW = 2'h1;
  localparam [1:0] PH_HIGH = 2'h2;
  localparam [1:0] PH_ISSUE = 2'h3;

  // Follow one valid request through both strobe edges
  // Strobe edges with no valid request only refresh the holding registers
  always @* begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        // Strobe zero may be seen in the same clock as the valid edge
        if (valid_fall && stb0_fall) begin
          next_phase = PH_HIGH;
        end else if (valid_fall) begin
          next_phase = PH_LOW;
        end
      end
      PH_LOW: begin
        // Waiting here keeps a stale lower half out of the request
        if (stb0_fall) begin
          next_phase = PH_HIGH;
        end
      end
      PH_HIGH: begin
        // A new valid edge abandons a request whose upper strobe never came
        if (valid_fall) begin
          next_phase = PH_LOW;
        end else if (stb1_fall) begin
          next_phase = PH_ISSUE;
        end
      end
      PH_ISSUE: begin
        // Hand-over clock; a valid edge here already opens the next request
        if (valid_fall) begin
          next_phase = PH_LOW;
        end else begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      low_half <= {(`APC_STB0_MSB-`APC_ADDR_LSB+1){1'b0}};
      high_half <= {(`APC_ADDR_MSB-`APC_STB1_LSB+1){1'b0}};
      req_held <= {`APC_REQ_W{1'b0}};
      par_held <= 2'h0;
      phase <= PH_IDLE;
      req_address <= {`APC_ADDR_W{1'b0}};
      req_type <= {`APC_REQ_W{1'b0}};
      req_start <= 1'b0;
      req_parity_error <= 1'b0;
      wrap_mask_active <= 1'b0;
    end else begin
      // Status follows the mask one clock after the synchroniser
      wrap_mask_active <= ~mask_sync;
      if (stb0_fall) begin
        low_half <= ~addr_sync[`APC_STB0_MSB-`APC_ADDR_LSB:0];
        req_held <= ~req_sync;
      end
      if (stb1_fall) begin
        high_half <= ~addr_sync[`APC_ADDR_W-1:`APC_STB1_LSB-`APC_ADDR_LSB];
        par_held <= ~par_sync;
      end
      phase <= next_phase;
      // Start decode, snoop and parity check once the upper half lands
      // The pulse follows the upper half by one clock, so parity sees the held word
      req_start <= 1'b0;
      if (phase == PH_ISSUE) begin
        // Address, type and error stand until the next request
        req_start <= 1'b1;
        req_address <= masked_addr;
        req_type <= req_held;
        req_parity_error <= par_bad;
      end
    end
  end

endmodule // apc_capture

`default_nettype wire

// [apc_regs.vh]
// Constants for the address-phase capture block of the processor system bus.
// Assumes a 10 MHz core clock; strobes and bus pins arrive asynchronously.
`ifndef APC_REGS_VH
`define APC_REGS_VH

`define APC_ADDR_MSB 35
`define APC_ADDR_LSB 3
`define APC_ADDR_W 33
`define APC_REQ_W 5
`define APC_STB0_MSB 16
`define APC_STB1_LSB 17
`define APC_WRAP_BIT 20
`define APC_SYNC_STAGES 2

`endif

// [apc_sync_edge.v]
// Two-flop synchroniser for one asynchronous level, with a falling-edge pulse.
// Assumes the input comes from outside the core clock domain.
`default_nettype none

module apc_sync_edge (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Asynchronous level in, synchronised level and falling pulse out
  input wire async_in,
  output wire level,
  output wire fall
);

  reg meta;
  reg stage;
  reg prev;

  always @(posedge clock) begin
    if (!resetn) begin
      meta <= 1'b1;
      stage <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= async_in;
      stage <= meta;
      prev <= stage;
    end
  end

  assign level = stage;
  assign fall = prev & ~stage;

endmodule // apc_sync_edge

`default_nettype wire

// [apc_checker.sv]
// Port assertions for apc_capture.
// Bound to every instance; bus pins idle high.
`default_nettype none
module apc_checker (
  // Watched ports
  input wire logic clock,
  input wire logic resetn,
  input wire logic address_capture_strobe_one_n,
  input wire logic address_valid_strobe_n,
  input wire logic address_wrap_mask_in_n,
  input wire logic [35:3] req_address,
  input wire logic [4:0] req_type,
  input wire logic req_start,
  input wire logic req_parity_error,
  input wire logic wrap_mask_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_issue;
    $fell(address_capture_strobe_one_n) && !address_valid_strobe_n;
  endsequence
  a_start_follows: assert property (s_issue |-> ##[3:8] req_start)
    else $error("no start");
  a_start_pulse: assert property (req_start |=> !req_start)
    else $error("long start");
  a_quiet_idle: assert property (address_capture_strobe_one_n [*8] |-> !req_start)
    else $error("stray start");
  a_type_hold: assert property ($changed(req_type) |-> req_start)
    else $error("type moved");
  a_error_hold: assert property ($changed(req_parity_error) |-> req_start)
    else $error("flag moved");
  a_wrap_clear: assert property (req_start && wrap_mask_active |-> !req_address[20])
    else $error("bit 20 set");
  a_mask_seen: assert property (!address_wrap_mask_in_n [*5] |-> wrap_mask_active)
    else $error("mask lost");
endmodule // apc_checker
bind apc_capture apc_checker i_chk (.clock, .resetn, .address_capture_strobe_one_n,
  .address_valid_strobe_n, .address_wrap_mask_in_n, .req_address, .req_type,
  .req_start, .req_parity_error, .wrap_mask_active);
`default_nettype wire

// [apc_agent.sv]
// Far-side bus agent issuing one address phase per call.
// Paced by the core clock; pins are pulled high when released.
`default_nettype none
module apc_agent (
  // Pacing clock and bus pins
  input wire logic clock,
  output logic [35:3] addr_n,
  output logic [4:0] type_n,
  output logic [1:0] address_parity_lines_n,
  output logic address_capture_strobe_zero_n,
  output logic address_capture_strobe_one_n,
  output logic address_valid_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic idle();
    {addr_n, type_n, address_parity_lines_n, address_capture_strobe_zero_n,
      address_capture_strobe_one_n, address_valid_strobe_n} = '1;
  endtask
  initial idle();
  task automatic issue(input logic [35:3] a, input logic [4:0] r, input logic bad, v);
    @(negedge clock);
    address_valid_strobe_n = !v;
    addr_n = ~a;
    type_n = ~r;
    address_parity_lines_n = ~{^a[23:3] ^ ^r, ^a[35:24] ^ bad};
    repeat (4) @(negedge clock);
    address_capture_strobe_zero_n = 1'b0;
    repeat (4) @(negedge clock);
    address_capture_strobe_one_n = 1'b0;
    repeat (8) @(negedge clock);
    idle();
    repeat (8) @(negedge clock);
  endtask
endmodule // apc_agent
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the address-phase capture block.
// The agent drives the bus pins; the bench drives the mask pin.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic address_wrap_mask_in_n = 1'b1;
  wire logic [35:3] addr_n, req_address;
  wire logic [4:0] type_n, req_type;
  wire logic [1:0] address_parity_lines_n;
  wire logic address_capture_strobe_zero_n, address_capture_strobe_one_n;
  wire logic address_valid_strobe_n, req_start, req_parity_error, wrap_mask_active;
  int fails = 0, num_checks = 0, starts = 0;
  logic [35:3] got_a;
  logic [4:0] got_t;
  logic got_e;
  apc_agent i_apc_agent (.clock, .addr_n, .type_n, .address_parity_lines_n,
    .address_capture_strobe_zero_n, .address_capture_strobe_one_n, .address_valid_strobe_n);
  apc_capture i_apc_capture (.clock, .resetn, .address_lines_n(addr_n), .request_lines_n(type_n),
    .address_parity_lines_n, .address_capture_strobe_zero_n, .address_capture_strobe_one_n,
    .address_valid_strobe_n, .address_wrap_mask_in_n, .req_address, .req_type, .req_start,
    .req_parity_error, .wrap_mask_active);
  initial forever #50 clock = ~clock;
  always @(negedge clock) if (req_start === 1'b1) begin
    starts++;
    {got_a, got_t, got_e} = {req_address, req_type, req_parity_error};
  end
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic go(input logic [35:3] a, ea, input logic [4:0] r, input logic bad, v);
    int s0;
    s0 = starts;
    i_apc_agent.issue(a, r, bad, v);
    check(starts - s0 == int'(v), "start count");
    if (v) check({got_a, got_t, got_e} === {ea, r, bad}, "captured request");
  endtask
  task automatic t_plain();
    go(33'h1_2345_6789, 33'h1_2345_6789, 5'h15, 1'b0, 1'b1);
    $display("plain done");
  endtask
  task automatic t_parity();
    go(33'h0_F00F_0008, 33'h0_F00F_0008, 5'h0A, 1'b1, 1'b1);
    $display("parity done");
  endtask
  task automatic t_refused();
    go(33'h0_0000_0FF8, 33'h0, 5'h1F, 1'b0, 1'b0);
    $display("refused done");
  endtask
  task automatic t_wrap();
    logic [35:3] ea;
    ea = '1;
    ea[20] = 1'b0;
    address_wrap_mask_in_n = 1'b0;
    repeat (5) @(negedge clock);
    check(wrap_mask_active === 1'b1, "mask on");
    go('1, ea, 5'h03, 1'b0, 1'b1);
    address_wrap_mask_in_n = 1'b1;
    repeat (5) @(negedge clock);
    check(wrap_mask_active === 1'b0, "mask off");
    $display("wrap done");
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    t_plain();
    t_parity();
    t_plain();
    t_refused();
    t_wrap();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
